// >>> hw/emb_bus_ctrl.sv
// external memory bus strobe, multiplexing and fetch-source control
`timescale 1ns/100ps
`default_nettype none

module emb_bus_ctrl #(
    parameter logic [15:0] INT_ROM_TOP = emb_pkg::EMB_INT_ROM_TOP
) (
    // clock, reset, enable
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_ce,
    // core request side
    input  wire emb_pkg::emb_req_t i_req,
    input  wire emb_pkg::emb_port_t i_port0_gpio,
    input  wire emb_pkg::emb_port_t i_port2_gpio,
    input  wire logic              i_ale_disable,
    input  wire logic              i_security_bit1,
    input  wire logic              i_program_pulse_input_mode,
    // core answer side
    output logic                   o_cycle_start,
    output logic                   o_fetch_internal,
    output logic                   o_fetch_valid,
    output logic [7:0]             o_fetch_data,
    output logic                   o_external_data_move_instruction_done,
    output logic [7:0]             o_external_data_move_instruction_rd_data,
    output logic                   o_program_pulse,
    // external pins
    input  wire logic              i_external_fetch_select_b,
    input  wire logic [7:0]        i_multiplexed_addr_data_port,
    input  wire logic              i_ale_pin,
    output emb_pkg::emb_port_t     o_multiplexed_addr_data_port,
    output emb_pkg::emb_port_t     o_high_address_port,
    output logic                   o_ale,
    output logic                   o_ale_oe_b,
    output logic                   o_program_fetch_strobe_b,
    output logic                   o_rd_b,
    output logic                   o_wr_b
);
    import emb_pkg::*;

    if (INT_ROM_TOP == 16'hffff)
    begin : g_bad_top
        $error("internal program memory top leaves no external fetch space");
    end

    // fetch goes outside when the select pin is low or past the internal top
    function automatic logic fetch_is_ext(input logic sel_b, input logic [15:0] addr);
        fetch_is_ext = !sel_b || (addr > INT_ROM_TOP); // [RULE_08] [RULE_09] [RULE_13]
    endfunction

    // sequencing state
    emb_slot_t  slot;
    emb_slot_t  next_slot;
    logic [2:0] ph;
    logic [2:0] next_ph;
    emb_req_t   req;
    emb_req_t   next_req;
    // fetch select capture
    logic       ea_caught;
    logic       next_ea_caught;
    logic       ea_latched;
    logic       next_ea_latched;
    // pin and answer registers
    emb_port_t  next_port0;
    emb_port_t  next_port2;
    logic       next_ale;
    logic       next_ale_oe_b;
    logic       next_program_fetch_strobe_b;
    logic       next_rd_b;
    logic       next_wr_b;
    logic       next_fetch_internal;
    logic       next_fetch_valid;
    logic [7:0] next_fetch_data;
    logic       next_external_data_move_instruction_done;
    logic [7:0] next_external_data_move_instruction_rd_data;
    logic       next_program_pulse;
    // helpers
    logic       cycle_end;
    logic       sel_b_now;
    logic [15:0] n_addr;
    logic       n_ext;
    logic       cur_ext;

    assign cycle_end     = (ph == EMB_PH_LAST) && (slot == EMB_SLOT_DATA);
    assign o_cycle_start = i_ce && cycle_end;

    // a pin level that is still uncaught is used directly, so the first cycle decides right
    assign sel_b_now = (i_security_bit1 && ea_caught) ? ea_latched : i_external_fetch_select_b;

    always_comb
    begin
        next_ea_caught  = 1'b1;
        next_ea_latched = ea_caught ? ea_latched : i_external_fetch_select_b; // [RULE_10]
    end

    // slot and phase sequencing; a new request is taken only at the cycle boundary
    always_comb
    begin
        next_ph   = (ph == EMB_PH_LAST) ? EMB_PH_ALE_FIRST : 3'(ph + 3'h1);
        next_slot = slot;
        if (ph == EMB_PH_LAST)
        begin
            next_slot = (slot == EMB_SLOT_ADDR) ? EMB_SLOT_DATA : EMB_SLOT_ADDR;
        end
        next_req = cycle_end ? i_req : req;
    end

    // pin values for the coming phase, so every pin leaves a flip-flop
    always_comb
    begin
        n_addr = next_req.external_data_move_instruction ? next_req.external_data_move_instruction_addr
               : ((next_slot == EMB_SLOT_ADDR) ? next_req.pc : 16'(next_req.pc + 16'h0001));
        n_ext  = next_req.external_data_move_instruction || fetch_is_ext(sel_b_now, n_addr);
        next_fetch_internal = !next_req.external_data_move_instruction && !n_ext; // [RULE_03]

        next_ale = 1'b0;
        if (!i_program_pulse_input_mode && (next_ph <= EMB_PH_ALE_LAST))
        begin
            if (next_req.external_data_move_instruction)
            begin
                next_ale = (next_slot == EMB_SLOT_ADDR); // [RULE_05] [RULE_06]
            end
            else
            begin
                next_ale = !i_ale_disable; // [RULE_04] [RULE_06]
            end
        end
        next_ale_oe_b = i_program_pulse_input_mode; // [RULE_12]

        next_program_fetch_strobe_b = EMB_STROBE_IDLE;
        if (!next_req.external_data_move_instruction && n_ext && (next_ph >= EMB_PH_STROBE))
        begin
            next_program_fetch_strobe_b = 1'b0; // [RULE_01] [RULE_02] [RULE_03]
        end

        next_rd_b = EMB_STROBE_IDLE;
        next_wr_b = EMB_STROBE_IDLE;
        if (next_req.external_data_move_instruction && !((next_slot == EMB_SLOT_ADDR) && (next_ph <= EMB_PH_ADDR_LAST)))
        begin
            next_rd_b = next_req.external_data_move_instruction_wr;
            next_wr_b = !next_req.external_data_move_instruction_wr;
        end

        // high byte holds for the whole access; the port is plain I/O otherwise
        if (n_ext)
        begin
            next_port2 = '{data: n_addr[15:8], oe_b: 1'b0}; // [RULE_11]
        end
        else
        begin
            next_port2 = i_port2_gpio; // [RULE_11]
        end

        if (!n_ext)
        begin
            next_port0 = i_port0_gpio;
        end
        else if ((next_ph <= EMB_PH_ADDR_LAST)
                 && !(next_req.external_data_move_instruction && (next_slot == EMB_SLOT_DATA)))
        begin
            next_port0 = '{data: n_addr[7:0], oe_b: 1'b0}; // [RULE_07]
        end
        else if (next_req.external_data_move_instruction && next_req.external_data_move_instruction_wr)
        begin
            next_port0 = '{data: next_req.wr_data, oe_b: 1'b0};
        end
        else
        begin
            next_port0 = EMB_PORT_IDLE;
        end
    end

    // read data is taken on the last phase of a strobe, while the memory still drives
    always_comb
    begin
        next_fetch_valid  = (ph == EMB_PH_LAST) && !o_program_fetch_strobe_b;
        next_fetch_data   = next_fetch_valid ? i_multiplexed_addr_data_port : o_fetch_data;
        next_external_data_move_instruction_done    = cycle_end && req.external_data_move_instruction;
        next_external_data_move_instruction_rd_data = (cycle_end && !o_rd_b) ? i_multiplexed_addr_data_port
                                                   : o_external_data_move_instruction_rd_data;
        next_program_pulse = i_program_pulse_input_mode && i_ale_pin; // [RULE_12]
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            slot       <= EMB_SLOT_DATA;
            ph         <= EMB_PH_LAST;
            req        <= EMB_REQ_RESET;
            ea_caught  <= 1'b0;
            ea_latched <= EMB_EA_RESET;
        end
        else if (i_ce)
        begin
            slot       <= next_slot;
            ph         <= next_ph;
            req        <= next_req;
            ea_caught  <= next_ea_caught;
            ea_latched <= next_ea_latched;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_multiplexed_addr_data_port <= EMB_PORT_IDLE;
            o_high_address_port          <= EMB_PORT_IDLE;
            o_ale                        <= 1'b0;
            o_ale_oe_b                   <= 1'b0;
            o_program_fetch_strobe_b     <= EMB_STROBE_IDLE;
            o_rd_b                       <= EMB_STROBE_IDLE;
            o_wr_b                       <= EMB_STROBE_IDLE;
            o_fetch_internal             <= 1'b0;
            o_fetch_valid                <= 1'b0;
            o_fetch_data                 <= 8'h00;
            o_external_data_move_instruction_done                  <= 1'b0;
            o_external_data_move_instruction_rd_data               <= 8'h00;
            o_program_pulse              <= 1'b0;
            cur_ext                      <= 1'b0;
        end
        else if (i_ce)
        begin
            o_multiplexed_addr_data_port <= next_port0;
            o_high_address_port          <= next_port2;
            o_ale                        <= next_ale;
            o_ale_oe_b                   <= next_ale_oe_b;
            o_program_fetch_strobe_b     <= next_program_fetch_strobe_b;
            o_rd_b                       <= next_rd_b;
            o_wr_b                       <= next_wr_b;
            o_fetch_internal             <= next_fetch_internal;
            o_fetch_valid                <= next_fetch_valid;
            o_fetch_data                 <= next_fetch_data;
            o_external_data_move_instruction_done                  <= next_external_data_move_instruction_done;
            o_external_data_move_instruction_rd_data               <= next_external_data_move_instruction_rd_data;
            o_program_pulse              <= next_program_pulse;
            cur_ext                      <= n_ext;
        end
    end

    // checks; a frozen clock enable stretches phases, so most checks tie state to pins
    logic [15:0] cur_addr;
    assign cur_addr = req.external_data_move_instruction ? req.external_data_move_instruction_addr
                    : ((slot == EMB_SLOT_ADDR) ? req.pc : 16'(req.pc + 16'h0001));

    sequence s_program_pulse_input_taken;
        (i_program_pulse_input_mode && i_ce) ##1 i_program_pulse_input_mode;
    endsequence

    sequence s_fetch_strobe;
        !o_program_fetch_strobe_b [*3];
    endsequence

    a_program_fetch_strobe_twice_cycle: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_01]
        (!req.external_data_move_instruction && cur_ext && ph == EMB_PH_STROBE) |-> !o_program_fetch_strobe_b)
        else $error("fetch strobe missing in an external fetch slot");

    a_program_fetch_strobe_strobe_len: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_01]
        (i_ce && ph == EMB_PH_ADDR_LAST && !next_program_fetch_strobe_b) |=> s_fetch_strobe)
        else $error("fetch strobe shape broken");

    a_program_fetch_strobe_strobe_end: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_01]
        (i_ce && ph == EMB_PH_LAST) |=> o_program_fetch_strobe_b)
        else $error("fetch strobe runs past its slot");

    a_program_fetch_strobe_external_data_move_instruction_skip: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_02]
        req.external_data_move_instruction |-> o_program_fetch_strobe_b)
        else $error("fetch strobe during a data access cycle");

    a_program_fetch_strobe_internal_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_03]
        o_fetch_internal |-> o_program_fetch_strobe_b)
        else $error("fetch strobe during an internal fetch");

    a_ale_free_run: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_04]
        (!req.external_data_move_instruction && !$past(i_program_pulse_input_mode) && !$past(i_ale_disable) && $past(i_ce)
         && ph <= EMB_PH_ALE_LAST && !i_program_pulse_input_mode) |-> o_ale)
        else $error("free running latch strobe missing");

    a_ale_external_data_move_instruction_drop: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_05]
        (req.external_data_move_instruction && slot == EMB_SLOT_DATA) |-> !o_ale)
        else $error("latch strobe not dropped in a data access");

    a_ale_inhibit: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_06]
        ($past(i_ce) && $past(i_ale_disable) && !req.external_data_move_instruction) |-> !o_ale)
        else $error("latch strobe present while disabled");

    a_ale_addr_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_07]
        (o_ale && cur_ext) |-> (!o_multiplexed_addr_data_port.oe_b
                                && o_multiplexed_addr_data_port.data == cur_addr[7:0]))
        else $error("low address not on the port under the latch strobe");

    a_sel_low_ext: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_08]
        ($past(i_ce) && $past(sel_b_now) == 1'b0 && !req.external_data_move_instruction) |-> !o_fetch_internal)
        else $error("internal fetch while fetch select is low");

    a_top_boundary: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_09]
        (!req.external_data_move_instruction && cur_addr > INT_ROM_TOP) |-> cur_ext)
        else $error("fetch above the internal top not external");

    a_sel_latched: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_10]
        ($past(ea_caught) && ea_caught) |-> $stable(ea_latched))
        else $error("caught fetch select changed after reset");

    a_hi_addr_drive: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_11]
        cur_ext |-> (!o_high_address_port.oe_b && o_high_address_port.data == cur_addr[15:8]))
        else $error("high address port not carrying the address");

    a_program_pulse_input_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_12]
        s_program_pulse_input_taken |-> (o_ale_oe_b && !o_ale))
        else $error("latch strobe pin driven in programming mode");

    a_strobe_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // [RULE_13]
        s_fetch_strobe |-> !o_ale)
        else $error("latch strobe high inside a fetch strobe");

endmodule

`default_nettype wire

// >>> shared/emb_pkg.sv
// constants and carrier types for the external memory bus control block
// Behaviour
// RULE_01: While code runs from external program memory the program fetch strobe pulses twice in every machine cycle.
// RULE_02: A machine cycle that performs an external data access leaves out both program fetch strobe pulses.
// RULE_03: The program fetch strobe stays inactive while instructions come from on-chip program memory.
// RULE_04: In normal operation the address latch strobe runs freely at one sixth of the oscillator rate.
// RULE_05: Every external data access drops exactly one address latch strobe pulse.
// RULE_06: With the latch strobe disable bit set the strobe appears only during an external data move instruction.
// RULE_07: The address latch strobe marks the low address byte on the multiplexed port for every external access.
// RULE_08: With the fetch select pin held low every program fetch, from address zero up, goes to external memory.
// RULE_09: With the fetch select pin high fetches are internal unless the program counter lies above the internal top.
// RULE_10: With security bit 1 programmed the fetch select pin is caught once at reset and later changes are ignored.
// RULE_11: The high address port carries address bits 8 to 15 during external accesses and is general I/O otherwise.
// RULE_12: In programming mode the latch strobe pin is released and read as the program pulse input.
// RULE_13: The program fetch strobe and fetch select pin are active low, the address latch strobe active high.
package emb_pkg;

    // oscillator periods in one machine cycle and in one half (slot)
    localparam int unsigned    EMB_CYCLE_OSC      = 12;
    localparam int unsigned    EMB_SLOT_OSC       = EMB_CYCLE_OSC / 2;
    localparam logic [2:0]     EMB_PH_LAST        = 3'(EMB_SLOT_OSC - 1);
    // phases inside a slot
    localparam logic [2:0]     EMB_PH_ALE_FIRST   = 3'h0;
    localparam logic [2:0]     EMB_PH_ALE_LAST    = 3'h1;
    localparam logic [2:0]     EMB_PH_ADDR_LAST   = 3'h2;
    localparam logic [2:0]     EMB_PH_STROBE      = 3'h3;
    // address map
    localparam logic [15:0]    EMB_INT_ROM_TOP    = 16'h3fff;
    localparam logic [15:0]    EMB_RESET_PC       = 16'h0000;
    // reset values
    localparam logic           EMB_STROBE_IDLE    = 1'b1;
    localparam logic           EMB_EA_RESET       = 1'b0;

    typedef enum logic {EMB_SLOT_ADDR, EMB_SLOT_DATA} emb_slot_t;

    // what the core wants done in the next machine cycle
    typedef struct packed {
        logic [15:0] pc;
        logic        external_data_move_instruction;
        logic        external_data_move_instruction_wr;
        logic [15:0] external_data_move_instruction_addr;
        logic [7:0]  wr_data;
    } emb_req_t;

    // one 8-bit two-way port: value and active-low output enable
    typedef struct packed {
        logic [7:0]  data;
        logic        oe_b;
    } emb_port_t;

    localparam emb_req_t       EMB_REQ_RESET  = '{pc: EMB_RESET_PC, external_data_move_instruction: 1'b0, external_data_move_instruction_wr: 1'b0,
                                                  external_data_move_instruction_addr: 16'h0000, wr_data: 8'h00};
    localparam emb_port_t      EMB_PORT_IDLE  = '{data: 8'hff, oe_b: 1'b1};

endpackage

// >>> verification/emb_ext_mem.sv
// external program and data memory model for the multiplexed bus
`timescale 1ns/100ps
`default_nettype none

module emb_ext_mem (
    // clock
    input  wire logic              i_core_clk,
    // bus from the device
    input  wire emb_pkg::emb_port_t i_low_port,
    input  wire emb_pkg::emb_port_t i_high_port,
    input  wire logic              i_ale,
    input  wire logic              i_fstb_b,
    input  wire logic              i_rd_b,
    input  wire logic              i_wr_b,
    // data back and write record
    output logic [7:0]             o_data,
    output logic [15:0]            o_wr_addr,
    output logic [7:0]             o_wr_data
);
    import emb_pkg::*;

    logic [15:0] addr = 16'h0000;
    logic [7:0]  last = 8'h00;
    logic        drive;

    always @(posedge i_core_clk)
    begin
        if (i_ale)
            addr <= {i_high_port.data, i_low_port.data};
        if (!i_wr_b)
        begin
            o_wr_addr <= addr;
            o_wr_data <= i_low_port.data;
        end
        if (drive)
            last <= o_data;
    end

    assign drive = !i_fstb_b || !i_rd_b;
    // a released bus shows the inverse of the last byte so stale sampling never matches
    assign o_data = drive ? (addr[7:0] ^ addr[15:8] ^ 8'h3c) : ~last;
endmodule

`default_nettype wire

// >>> verification/tb_external_memory_bus_control.sv
// self-checking bench for the external memory bus control block
`timescale 1ns/100ps
`default_nettype none

module tb_external_memory_bus_control;
    import emb_pkg::*;

    logic        clk, rst_b, ce, ale_dis, sec1, program_pulse_input, sel_b, ale_ext;
    logic        ale, ale_oe_b, fstb_b, rd_b, wr_b, cstart, fint, fvalid, mdone, ppulse, fi;
    logic [7:0]  fdata, mdata, mem_data, wdata, md;
    logic [15:0] waddr;
    emb_req_t    req;
    emb_port_t   gpio, p0, p2, p2a;
    logic [7:0]  fd [2];
    int          errors, checks_done, n_ale, n_fs, n_fv, n_md;

    emb_bus_ctrl i_dut (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_req(req),
        .i_port0_gpio(gpio), .i_port2_gpio(gpio), .i_ale_disable(ale_dis),
        .i_security_bit1(sec1), .i_program_pulse_input_mode(program_pulse_input), .o_cycle_start(cstart),
        .o_fetch_internal(fint), .o_fetch_valid(fvalid), .o_fetch_data(fdata),
        .o_external_data_move_instruction_done(mdone), .o_external_data_move_instruction_rd_data(mdata), .o_program_pulse(ppulse),
        .i_external_fetch_select_b(sel_b),
        .i_multiplexed_addr_data_port(p0.oe_b ? mem_data : p0.data),
        .i_ale_pin(ale_oe_b ? ale_ext : ale), .o_multiplexed_addr_data_port(p0),
        .o_high_address_port(p2), .o_ale(ale), .o_ale_oe_b(ale_oe_b),
        .o_program_fetch_strobe_b(fstb_b), .o_rd_b(rd_b), .o_wr_b(wr_b)
    );

    emb_ext_mem i_mem (
        .i_core_clk(clk), .i_low_port(p0), .i_high_port(p2), .i_ale(ale),
        .i_fstb_b(fstb_b), .i_rd_b(rd_b), .i_wr_b(wr_b), .o_data(mem_data),
        .o_wr_addr(waddr), .o_wr_data(wdata)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    function automatic emb_req_t mk(input logic [15:0] pc, input logic mv, input logic wr,
                                    input logic [15:0] ma, input logic [7:0] wd);
        return '{pc: pc, external_data_move_instruction: mv, external_data_move_instruction_wr: wr, external_data_move_instruction_addr: ma, wr_data: wd};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic do_reset(input logic s);
        @(posedge clk);
        rst_b <= 1'b0;
        sec1 <= s;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
    endtask

    // runs one machine cycle and counts strobe pulses; k0 is skipped for answers
    // because a repeated request of the previous cycle lands its last byte there
    task automatic cyc(input emb_req_t r);
        int   n;
        logic pa;
        logic pf;
        @(posedge clk);
        req <= r;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (cstart !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            errors++;
            report_and_stop();
        end
        {n_ale, n_fs, n_fv, n_md} = '0;
        pa = 1'b0;
        pf = 1'b1;
        for (int k = 0; k < 13; k++)
        begin
            @(negedge clk);
            if (k == 0)
                p2a = p2;
            if (k == 1)
                fi = fint;
            if (k < 12 && ale === 1'b1 && !pa)
                n_ale++;
            if (k < 12 && fstb_b === 1'b0 && pf)
                n_fs++;
            pa = ale;
            pf = fstb_b;
            if (k > 0 && fvalid === 1'b1)
            begin
                fd[n_fv % 2] = fdata;
                n_fv++;
            end
            if (k > 0 && mdone === 1'b1)
            begin
                md = mdata;
                n_md++;
            end
        end
    endtask

    task automatic t_ext_fetch;
        cyc(mk(16'h1234, 1'b0, 1'b0, 16'h0000, 8'h00));
        chk(16'(n_fs), 16'h0002);
        chk(16'(n_ale), 16'h0002);
        chk(16'(n_fv), 16'h0002);
        chk({fd[0], fd[1]}, {mem_byte(16'h1234), mem_byte(16'h1235)});
        chk({p2a.data, 7'h00, p2a.oe_b}, 16'h1200);
        chk(16'(fi), 16'h0000);
        $display("external fetch test done");
    endtask

    task automatic t_int_fetch;
        @(posedge clk);
        sel_b <= 1'b1;
        cyc(mk(16'h0100, 1'b0, 1'b0, 16'h0000, 8'h00));
        chk(16'(n_fs), 16'h0000);
        chk(16'(n_ale), 16'h0002);
        chk({p2a.data, 7'h00, p2a.oe_b}, {gpio.data, 7'h00, gpio.oe_b});
        chk(16'(fi), 16'h0001);
        cyc(mk(16'h3fff, 1'b0, 1'b0, 16'h0000, 8'h00));
        chk(16'(n_fs), 16'h0001);
        chk(16'(fi), 16'h0001);
        cyc(mk(16'h4000, 1'b0, 1'b0, 16'h0000, 8'h00));
        chk(16'(n_fs), 16'h0002);
        $display("internal fetch test done");
    endtask

    task automatic t_data_move;
        cyc(mk(16'h0100, 1'b1, 1'b0, 16'h8a51, 8'h00));
        chk(16'(n_fs), 16'h0000);
        chk(16'(n_ale), 16'h0001);
        chk({8'(n_md), md}, {8'h01, mem_byte(16'h8a51)});
        @(posedge clk);
        ale_dis <= 1'b1;
        cyc(mk(16'h0100, 1'b0, 1'b0, 16'h0000, 8'h00));
        chk(16'(n_ale), 16'h0000);
        cyc(mk(16'h0100, 1'b1, 1'b1, 16'hc3e1, 8'h96));
        chk(16'(n_ale), 16'h0001);
        chk(16'(n_fs), 16'h0000);
        chk(waddr, 16'hc3e1);
        chk(16'(wdata), 16'h0096);
        @(posedge clk);
        ale_dis <= 1'b0;
        $display("data move test done");
    endtask

    task automatic t_secure_latch;
        @(posedge clk);
        sel_b <= 1'b0;
        do_reset(1'b1);
        repeat (3) @(posedge clk);
        sel_b <= 1'b1;
        cyc(mk(16'h0100, 1'b0, 1'b0, 16'h0000, 8'h00));
        chk(16'(n_fs), 16'h0002);
        $display("fetch select latch test done");
    endtask

    // a low clock enable must stretch the fetch strobe instead of letting it time out
    task automatic t_freeze;
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (fstb_b !== 1'b0 && n < 40);
        if (n >= 40)
        begin
            errors++;
            report_and_stop();
        end
        @(posedge clk);
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({15'h0000, fstb_b}, 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk({15'h0000, fstb_b}, 16'h0000);
        @(posedge clk);
        @(negedge clk);
        chk({15'h0000, fstb_b}, 16'h0001);
        $display("clock enable freeze test done");
    endtask

    task automatic t_program_pulse_input;
        @(posedge clk);
        program_pulse_input <= 1'b1;
        ale_ext <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0000, ale_oe_b}, 16'h0001);
        chk({15'h0000, ppulse}, 16'h0001);
        @(posedge clk);
        ale_ext <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0000, ppulse}, 16'h0000);
        $display("programming pin test done");
    endtask

    initial
    begin
        errors = 0;
        checks_done = 0;
        rst_b = 1'b0;
        {ale_dis, sec1, program_pulse_input, sel_b, ale_ext} = '0;
        ce = 1'b1;
        gpio = '{data: 8'ha5, oe_b: 1'b0};
        req = EMB_REQ_RESET;
        do_reset(1'b0);
        t_ext_fetch();
        t_int_fetch();
        t_data_move();
        t_secure_latch();
        t_freeze();
        t_program_pulse_input();
        report_and_stop();
    end
endmodule

`default_nettype wire
